/* File: bwa_pkg.sv */
package bwa_pkg;
    // register port
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_INT_STAT  = 8'h08;
    localparam logic [7:0] OFF_INT_MASK  = 8'h0c;
    localparam logic [7:0] OFF_PHASE_MAP = 8'h10;
    // field positions
    localparam int CTRL_START   = 0;
    localparam int ST_READY     = 0;
    localparam int ST_BIT       = 1;
    localparam int ST_WORD      = 2;
    localparam int ST_FAIL      = 3;
    localparam int ST_BUSY      = 4;
    localparam int ST_EYE_LSB   = 8;
    localparam int INT_BIT      = 0;
    localparam int INT_WORD     = 1;
    localparam int INT_FAIL     = 2;
    localparam int INT_W        = 3;
    // alignment figures
    localparam int             PH_W        = 4;
    localparam int             EYE_W       = 5;
    localparam int             WORD_W      = 7;
    localparam logic [4:0]     NUM_PHASES  = 5'h10;
    localparam logic [3:0]     LAST_PHASE  = 4'hf;
    localparam logic [4:0]     MIN_EYE     = 5'h03;
    localparam logic [6:0]     CLK_PATTERN = 7'h63;
    localparam logic [2:0]     MAX_ROT     = 3'h7;
    localparam logic [5:0]     SCAN_LAST   = 6'h1f;
    localparam logic [3:0]     SETTLE_CYC  = 4'h8;
    localparam logic [2:0]     SAMPLES     = 3'h4;
    localparam logic           PHASE_FWD   = 1'b0;

    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_WAIT_PLL = 4'b0001,
        S_SWEEP_WT = 4'b0010,
        S_SAMPLE   = 4'b0011,
        S_STEP     = 4'b0100,
        S_SCAN     = 4'b0101,
        S_MOVE     = 4'b0110,
        S_MOVE_WT  = 4'b0111,
        S_WCHECK   = 4'b1000,
        S_ROT_WT   = 4'b1001,
        S_DONE     = 4'b1010,
        S_FAIL     = 4'b1011
    } bwa_state_t;
endpackage

/* File: bwa_bit_word_aligner.sv */
// How it works
// - Whole aligner runs on the divided receive clock of the 7:1 path.
// - While reset is asserted every output is held at zero.
// - Alignment waits until the PLL lock input has gone high.
// - An update request starts alignment, or restarts it from the beginning.
// - Phase direction output is fixed to forward, logic zero.
// - Bit alignment steps the PLL through all 16 phases.
// - At each phase the clock lane word is checked; phases near transitions flagged.
// - Final phase is the one farthest from any flagged transition.
// - Lock needs an eye of at least three of sixteen points per bit.
// - Eye width output reports the final valid window size.
// - Bit aligned flag rises once bit alignment succeeds.
// - Word alignment begins only after bit alignment is done.
// - Each rotate pulse shifts the deserializer word by two bits.
// - At most seven rotate pulses visit all seven framings.
// - Word alignment ends when the clock word equals 7'h63.
// - Word aligned flag rises once the framing is found.
// - Ready rises only after the whole procedure has finished.
`timescale 1ns/1ps
module bwa_bit_word_aligner
    import bwa_pkg::*;
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    // pll and deserializer side
    input  wire logic              i_pll_locked,
    input  wire logic              i_update,
    input  wire logic [WORD_W-1:0] i_clock_lane_word,
    output logic                   o_phase_advance_pulse,
    output logic                   o_phase_direction,
    output logic                   o_word_rotate_pulse,
    // status
    output logic [EYE_W-1:0]       o_eye_width,
    output logic                   o_bit_aligned_flag,
    output logic                   o_word_aligned_flag,
    output logic                   o_ready,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [DATA_W-1:0]      o_rd_data,
    output logic                   o_irq
);

    // true when w is some rotation of the clock pattern
    function automatic logic clock_shaped(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        logic              hit;
        r   = CLK_PATTERN;
        hit = 1'b0;
        for (int i = 0; i < WORD_W; i++) begin
            if (w == r) begin
                hit = 1'b1;
            end
            r = {r[WORD_W-2:0], r[WORD_W-1]};
        end
        return hit;
    endfunction

    bwa_state_t        state_reg;
    bwa_state_t        state_next;
    logic              lock_s1_reg;
    logic              lock_s2_reg;
    logic [3:0]        wait_reg;
    logic [2:0]        samp_reg;
    logic [WORD_W-1:0] ref_word_reg;
    logic              bad_reg;
    logic [15:0]       good_map_reg;
    logic [PH_W-1:0]   cur_phase_reg;
    logic [PH_W-1:0]   target_reg;
    logic [PH_W-1:0]   sweep_base_reg;
    logic [5:0]        scan_reg;
    logic [EYE_W-1:0]  run_reg;
    logic [EYE_W-1:0]  best_reg;
    logic [PH_W-1:0]   best_end_reg;
    logic [2:0]        rot_reg;
    logic              step_reg;
    logic              rot_pulse_reg;
    logic              dir_reg;
    logic [EYE_W-1:0]  eye_reg;
    logic              bit_ok_reg;
    logic              word_ok_reg;
    logic              ready_reg;
    logic              fail_reg;
    logic [INT_W-1:0]  int_stat_reg;
    logic [INT_W-1:0]  int_mask_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic              irq_reg;

    // register decode
    wire wr_ctrl  = i_wr && (i_addr == OFF_CTRL);
    wire wr_istat = i_wr && (i_addr == OFF_INT_STAT);
    wire wr_imask = i_wr && (i_addr == OFF_INT_MASK);
    wire start_req = i_update | (wr_ctrl & i_wr_data[CTRL_START]);

    wire wait_done = (wait_reg == 4'h0);
    wire samp_last = (samp_reg == SAMPLES - 3'h1);
    // pll phase is not reset by a restart, so the sweep ends one short of its start
    wire [PH_W-1:0] sweep_end = sweep_base_reg - 4'h1;
    wire sweep_last = (cur_phase_reg == sweep_end);
    wire word_diff = (samp_reg != 3'h0) && (i_clock_lane_word != ref_word_reg);
    wire near_edge = bad_reg | word_diff | ~clock_shaped(i_clock_lane_word);
    wire scan_good = good_map_reg[scan_reg[3:0]];
    wire [EYE_W-1:0] run_inc = (run_reg == NUM_PHASES) ? run_reg : run_reg + 5'h01;
    wire scan_best = scan_good && (run_inc > best_reg);
    wire scan_end  = (scan_reg == SCAN_LAST);
    // eye at least three of sixteen points
    wire eye_ok    = (best_reg >= MIN_EYE);
    wire [PH_W-1:0] centre = best_end_reg - best_reg[PH_W:1];
    wire word_match = (i_clock_lane_word == CLK_PATTERN);

    wire [INT_W-1:0] int_set;
    assign int_set[INT_BIT]  = (state_reg == S_MOVE_WT) && wait_done &&
                               (cur_phase_reg == target_reg);
    assign int_set[INT_WORD] = (state_reg == S_WCHECK) && word_match;
    assign int_set[INT_FAIL] = (state_next == S_FAIL) && (state_reg != S_FAIL);
    wire [INT_W-1:0] int_clr = wr_istat ? i_wr_data[INT_W-1:0] : {INT_W{1'b0}};
    // set wins over a clear in the same cycle
    wire [INT_W-1:0] int_next = (int_stat_reg & ~int_clr) | int_set;

    wire [DATA_W-1:0] status_word = {
        {(DATA_W - ST_EYE_LSB - EYE_W){1'b0}}, eye_reg, 3'h0,
        (state_reg != S_IDLE) && !ready_reg && !fail_reg,
        fail_reg, word_ok_reg, bit_ok_reg, ready_reg
    };
    wire [DATA_W-1:0] rd_mux =
        (i_addr == OFF_STATUS)    ? status_word :
        (i_addr == OFF_INT_STAT)  ? {{(DATA_W-INT_W){1'b0}}, int_stat_reg} :
        (i_addr == OFF_INT_MASK)  ? {{(DATA_W-INT_W){1'b0}}, int_mask_reg} :
        (i_addr == OFF_PHASE_MAP) ? {16'h0000, good_map_reg} :
        {DATA_W{1'b0}};

    // sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                state_next = S_IDLE;
            end
            S_WAIT_PLL: begin
                if (lock_s2_reg) begin
                    state_next = S_SWEEP_WT;
                end
            end
            S_SWEEP_WT: begin
                if (wait_done) begin
                    state_next = S_SAMPLE;
                end
            end
            // sixteen phases from the start point
            S_SAMPLE: begin
                if (samp_last) begin
                    state_next = sweep_last ? S_SCAN : S_STEP;
                end
            end
            S_STEP: begin
                state_next = S_SWEEP_WT;
            end
            S_SCAN: begin
                if (scan_end) begin
                    // target settles before the first compare
                    state_next = eye_ok ? S_MOVE_WT : S_FAIL;
                end
            end
            S_MOVE: begin
                state_next = S_MOVE_WT;
            end
            S_MOVE_WT: begin
                if (wait_done) begin
                    state_next = (cur_phase_reg == target_reg) ? S_WCHECK : S_MOVE;
                end
            end
            S_WCHECK: begin
                if (word_match) begin
                    state_next = S_DONE;
                end else if (rot_reg == MAX_ROT) begin
                    state_next = S_FAIL;
                end else begin
                    state_next = S_ROT_WT;
                end
            end
            S_ROT_WT: begin
                if (wait_done) begin
                    state_next = S_WCHECK;
                end
            end
            S_DONE: begin
                state_next = S_DONE;
            end
            S_FAIL: begin
                state_next = S_FAIL;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (start_req) begin
            state_next = S_WAIT_PLL;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg   <= S_IDLE;
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            lock_s1_reg <= i_pll_locked;
            lock_s2_reg <= lock_s1_reg;
        end
    end

    // settle and sample counters
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg     <= 4'h0;
            samp_reg     <= 3'h0;
            ref_word_reg <= '0;
            bad_reg      <= 1'b0;
        end else begin
            if (state_next != state_reg) begin
                wait_reg <= SETTLE_CYC;
            end else if (!wait_done) begin
                wait_reg <= wait_reg - 4'h1;
            end
            if (state_reg == S_SAMPLE) begin
                samp_reg <= samp_reg + 3'h1;
                bad_reg  <= near_edge;
                if (samp_reg == 3'h0) begin
                    ref_word_reg <= i_clock_lane_word;
                end
            end else begin
                samp_reg <= 3'h0;
                bad_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_reg       <= 1'b0;
            cur_phase_reg  <= '0;
            good_map_reg   <= 16'h0000;
            sweep_base_reg <= '0;
        end else begin
            step_reg <= 1'b0;
            // sweep starts wherever the pll phase stands
            if (state_reg == S_WAIT_PLL) begin
                sweep_base_reg <= cur_phase_reg;
            end
            if ((state_reg == S_SAMPLE) && samp_last) begin
                good_map_reg[cur_phase_reg] <= ~near_edge;
            end
            if ((state_reg == S_STEP) ||
                ((state_reg == S_MOVE) && (cur_phase_reg != target_reg))) begin
                step_reg      <= 1'b1;
                cur_phase_reg <= cur_phase_reg + 4'h1;
            end
        end
    end

    // widest circular run of good phases
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scan_reg     <= '0;
            run_reg      <= '0;
            best_reg     <= '0;
            best_end_reg <= '0;
            target_reg   <= '0;
        end else if (state_reg == S_SCAN) begin
            scan_reg <= scan_reg + 6'h01;
            run_reg  <= scan_good ? run_inc : 5'h00;
            if (scan_best) begin
                best_reg     <= run_inc;
                best_end_reg <= scan_reg[3:0];
            end
        end else begin
            if (state_reg == S_SAMPLE) begin
                scan_reg <= '0;
                run_reg  <= '0;
                best_reg <= '0;
            end
            target_reg <= centre;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rot_pulse_reg <= 1'b0;
            rot_reg       <= 3'h0;
        end else begin
            rot_pulse_reg <= 1'b0;
            if (start_req) begin
                rot_reg <= 3'h0;
            end else if (state_next == S_ROT_WT && state_reg == S_WCHECK) begin
                // one pulse moves framing by two bits
                rot_pulse_reg <= 1'b1;
                rot_reg       <= rot_reg + 3'h1;
            end
        end
    end

    // status flags
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_reg     <= 1'b0;
            eye_reg     <= '0;
            bit_ok_reg  <= 1'b0;
            word_ok_reg <= 1'b0;
            ready_reg   <= 1'b0;
            fail_reg    <= 1'b0;
        end else if (start_req) begin
            dir_reg     <= PHASE_FWD;
            eye_reg     <= '0;
            bit_ok_reg  <= 1'b0;
            word_ok_reg <= 1'b0;
            ready_reg   <= 1'b0;
            fail_reg    <= 1'b0;
        end else begin
            dir_reg <= PHASE_FWD;
            if (state_reg == S_SCAN && scan_end) begin
                eye_reg <= best_reg;
            end
            if (int_set[INT_BIT]) begin
                bit_ok_reg <= 1'b1;
            end
            if (int_set[INT_WORD]) begin
                word_ok_reg <= 1'b1;
                ready_reg   <= 1'b1;
            end
            if (int_set[INT_FAIL]) begin
                fail_reg <= 1'b1;
            end
        end
    end

    // register port and interrupt
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
            rd_data_reg  <= '0;
            irq_reg      <= 1'b0;
        end else begin
            int_stat_reg <= int_next;
            if (wr_imask) begin
                int_mask_reg <= i_wr_data[INT_W-1:0];
            end
            rd_data_reg <= i_rd ? rd_mux : {DATA_W{1'b0}};
            irq_reg     <= |(int_next & (wr_imask ? i_wr_data[INT_W-1:0] : int_mask_reg));
        end
    end

    assign o_phase_advance_pulse = step_reg;
    assign o_phase_direction     = dir_reg;
    assign o_word_rotate_pulse   = rot_pulse_reg;
    assign o_eye_width           = eye_reg;
    assign o_bit_aligned_flag    = bit_ok_reg;
    assign o_word_aligned_flag   = word_ok_reg;
    assign o_ready               = ready_reg;
    assign o_rd_data             = rd_data_reg;
    assign o_irq                 = irq_reg;

endmodule

/* File: bwa_checker.sv */
`timescale 1ns/1ps
module bwa_checker
    import bwa_pkg::*;
(
    // clock and reset
    input wire logic              i_mclk,
    input wire logic              i_rst_n,
    // link side
    input wire logic              i_pll_locked,
    input wire logic              i_update,
    input wire logic [WORD_W-1:0] i_clock_lane_word,
    input wire logic              o_phase_advance_pulse,
    input wire logic              o_phase_direction,
    input wire logic              o_word_rotate_pulse,
    // status
    input wire logic [EYE_W-1:0]  o_eye_width,
    input wire logic              o_bit_aligned_flag,
    input wire logic              o_word_aligned_flag,
    input wire logic              o_ready,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rd_data,
    input wire logic              o_irq
);
    logic [3:0] rot_cnt_reg;
    logic [3:0] rot_cnt_next;
    wire        start_req;
    // rotations since the last start
    assign start_req = i_update | (i_wr & (i_addr == OFF_CTRL) & i_wr_data[CTRL_START]);
    assign rot_cnt_next = start_req ? 4'h0 : rot_cnt_reg + {3'h0, o_word_rotate_pulse};
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rot_cnt_reg <= 4'h0;
        end else begin
            rot_cnt_reg <= rot_cnt_next;
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_step_quiet;
        !o_phase_advance_pulse [*8];
    endsequence
    sequence s_rot_quiet;
        !o_word_rotate_pulse [*8];
    endsequence
    a_reset_outputs_zero: assert property ($rose(i_rst_n) |-> o_rd_data == '0
        && {o_phase_advance_pulse, o_phase_direction, o_word_rotate_pulse, o_eye_width,
            o_bit_aligned_flag, o_word_aligned_flag, o_ready, o_irq} == '0)
        else $error("outputs not zero after reset");
    a_dir_forward: assert property (o_phase_direction == PHASE_FWD)
        else $error("phase direction not forward");
    a_wait_lock: assert property (!i_pll_locked [*3] |-> !o_phase_advance_pulse)
        else $error("phase step without pll lock");
    a_step_settle: assert property (o_phase_advance_pulse |=> s_step_quiet)
        else $error("phase step too soon");
    a_rot_settle: assert property (o_word_rotate_pulse |=> s_rot_quiet)
        else $error("word rotate too soon");
    a_word_after_bit: assert property (o_word_rotate_pulse |-> o_bit_aligned_flag)
        else $error("word rotate before bit lock");
    a_rot_bound: assert property (rot_cnt_reg <= 4'h7)
        else $error("more than seven rotations");
    a_word_match: assert property ($rose(o_word_aligned_flag) |->
        i_clock_lane_word == CLK_PATTERN)
        else $error("word lock without clock pattern");
    a_eye_minimum: assert property ($rose(o_bit_aligned_flag) |-> o_eye_width >= MIN_EYE)
        else $error("bit lock with narrow eye");
    a_ready_done: assert property (o_ready |-> o_bit_aligned_flag && o_word_aligned_flag)
        else $error("ready before alignment done");
    a_start_clears: assert property (i_update |=> !o_ready && !o_bit_aligned_flag
        && !o_word_aligned_flag && o_eye_width == '0)
        else $error("start did not clear status");
endmodule
bind bwa_bit_word_aligner bwa_checker u_chk (.i_mclk, .i_rst_n, .i_pll_locked, .i_update,
    .i_clock_lane_word, .o_phase_advance_pulse, .o_phase_direction, .o_word_rotate_pulse,
    .o_eye_width, .o_bit_aligned_flag, .o_word_aligned_flag, .o_ready, .i_addr, .i_wr_data,
    .i_wr, .i_rd, .o_rd_data, .o_irq);

/* File: bwa_link_model.sv */
`timescale 1ns/1ps
module bwa_link_model
    import bwa_pkg::*;
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    // eye and framing setup
    input  wire logic [PH_W-1:0]   i_good_lo,
    input  wire logic [PH_W-1:0]   i_good_hi,
    input  wire logic [2:0]        i_rot0,
    // aligner side
    input  wire logic              i_phase_advance_pulse,
    input  wire logic              i_phase_direction,
    input  wire logic              i_word_rotate_pulse,
    output logic [WORD_W-1:0]      o_clock_lane_word,
    // observation
    output logic [PH_W-1:0]        o_phase,
    output logic [3:0]             o_rots
);
    logic [2:0]        frame_reg;
    logic              flip_reg;
    logic [WORD_W-1:0] framed;
    wire               good;
    assign good = (o_phase >= i_good_lo) && (o_phase <= i_good_hi);
    always_comb begin
        framed = CLK_PATTERN;
        for (int k = 0; k < 7; k++) begin
            if (k < int'(frame_reg)) framed = {framed[4:0], framed[6:5]};
        end
    end
    // phase steps, unstable word off the eye
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase <= '0;
            frame_reg <= i_rot0;
            o_rots <= 4'h0;
            flip_reg <= 1'b0;
            o_clock_lane_word <= '0;
        end else begin
            flip_reg <= ~flip_reg;
            o_clock_lane_word <= (good || flip_reg) ? framed : ~framed;
            if (i_phase_advance_pulse) begin
                o_phase <= (i_phase_direction == PHASE_FWD) ? o_phase + 4'h1 : o_phase - 4'h1;
            end
            if (i_word_rotate_pulse) begin
                frame_reg <= (frame_reg == 3'h6) ? 3'h0 : frame_reg + 3'h1;
                o_rots <= o_rots + 4'h1;
            end
        end
    end
endmodule

/* File: bwa_bit_word_aligner_tb.sv */
`timescale 1ns/1ps
module bwa_bit_word_aligner_tb
    import bwa_pkg::*;
;
    logic              i_mclk = 1'b0;
    logic              i_rst_n = 1'b0;
    logic              i_pll_locked = 1'b0;
    logic              i_update = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wr_data = '0;
    logic              i_wr = 1'b0;
    logic              i_rd = 1'b0;
    logic              m_rst_n = 1'b0;
    logic [PH_W-1:0]   good_lo = 4'h4;
    logic [PH_W-1:0]   good_hi = 4'ha;
    logic [2:0]        rot0 = 3'h3;
    logic [DATA_W-1:0] s;
    wire  [WORD_W-1:0] word;
    wire               step, dir, rot, bitf, wordf, rdy, irq;
    wire  [EYE_W-1:0]  eye;
    wire  [DATA_W-1:0] rd_data;
    wire  [PH_W-1:0]   phase;
    wire  [3:0]        rots;
    int                miscompares = 0;
    int                n_tests = 0;
    always #5 i_mclk = ~i_mclk;
    bwa_bit_word_aligner dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pll_locked(i_pll_locked),
        .i_update(i_update), .i_clock_lane_word(word), .o_phase_advance_pulse(step),
        .o_phase_direction(dir), .o_word_rotate_pulse(rot), .o_eye_width(eye),
        .o_bit_aligned_flag(bitf), .o_word_aligned_flag(wordf), .o_ready(rdy),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(rd_data), .o_irq(irq));
    bwa_link_model u_link (.i_mclk(i_mclk), .i_rst_n(m_rst_n), .i_good_lo(good_lo),
        .i_good_hi(good_hi), .i_rot0(rot0), .i_phase_advance_pulse(step),
        .i_phase_direction(dir), .i_word_rotate_pulse(rot), .o_clock_lane_word(word),
        .o_phase(phase), .o_rots(rots));
    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rdv(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        rdv(a, d);
        chk(d, exp);
    endtask
    task automatic start(input logic by_pin);
        if (by_pin) begin
            @(posedge i_mclk);
            i_update <= 1'b1;
            @(posedge i_mclk);
            i_update <= 1'b0;
        end else begin
            wr(OFF_CTRL, 32'h1);
        end
    endtask
    task automatic poll();
        s = '0;
        for (int k = 0; k < 1500 && s[ST_READY] !== 1'b1 && s[ST_FAIL] !== 1'b1; k++) begin
            rdv(OFF_STATUS, s);
        end
    endtask
    task automatic run(input logic [3:0] lo, input logic [3:0] hi, input logic [2:0] r,
                       input logic by_pin);
        @(posedge i_mclk);
        good_lo <= lo;
        good_hi <= hi;
        rot0 <= r;
        m_rst_n <= 1'b0;
        @(posedge i_mclk);
        m_rst_n <= 1'b1;
        start(by_pin);
        poll();
    endtask
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
    initial begin
        wt(1);
        chk(32'({step, dir, rot, bitf, wordf, rdy, irq, eye}), 32'h0);
        chk(rd_data, 32'h0);
        wt(2);
        i_rst_n <= 1'b1;
        m_rst_n <= 1'b1;
        start(1'b1);
        wt(60);
        chk(32'(phase), 32'h0);
        i_pll_locked <= 1'b1;
        poll();
        chk(s, 32'h0707);
        chk(32'({bitf, wordf, rdy, eye}), 32'he7);
        chk(32'(phase), 32'h7);
        chk(32'(rots), 32'h4);
        chk(32'(word), 32'h63);
        rd(OFF_PHASE_MAP, 32'h07f0);
        rd(OFF_INT_STAT, 32'h3);
        chk(32'(irq), 32'h0);
        wr(OFF_INT_MASK, 32'h7);
        wt(2);
        chk(32'(irq), 32'h1);
        rd(OFF_INT_MASK, 32'h7);
        wr(OFF_INT_STAT, 32'h3);
        wt(2);
        chk(32'(irq), 32'h0);
        rd(OFF_INT_STAT, 32'h0);
        rd(OFF_CTRL, 32'h0);
        rd(8'h40, 32'h0);
        run(4'h4, 4'h5, 3'h0, 1'b0);
        chk(s & 32'h1f, 32'h08);
        chk(32'({bitf, wordf, rdy}), 32'h0);
        rd(OFF_INT_STAT, 32'h4);
        chk(32'(irq), 32'h1);
        run(4'h2, 4'h4, 3'h6, 1'b1);
        chk(s, 32'h0307);
        chk(32'(phase), 32'h3);
        chk(32'(rots), 32'h1);
        conclude();
    end
endmodule
